// file: rtl/stc_pkg.sv
// package for the sixteen-bit timer counter
package stc_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] STC_IDX_FLAGS = 8'h0C;
    localparam logic [7:0] STC_IDX_CNT_LO = 8'h0E;
    localparam logic [7:0] STC_IDX_CNT_HI = 8'h0F;
    localparam logic [7:0] STC_IDX_CTRL = 8'h10;
    localparam logic [7:0] STC_IDX_ENABLES = 8'h8C;
    localparam logic [7:0] STC_IDX_FLAG_CLR = 8'h90;
    localparam int STC_ADDR_W = 10;
    // control field positions
    localparam int STC_CTRL_ON = 0;
    localparam int STC_CTRL_CS = 1;
    localparam int STC_CTRL_SYNCB = 2;
    localparam int STC_CTRL_OSCEN = 3;
    localparam int STC_CTRL_PS_LO = 4;
    localparam int STC_FLAG_OVF = 0;
    localparam logic [5:0] STC_CTRL_MASK = 6'h3F;
    localparam logic [7:0] STC_RESET_BYTE = 8'h00;
    localparam logic [15:0] STC_COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] STC_COUNT_ZERO = 16'h0000;
    localparam logic [1:0] STC_RESP_OKAY = 2'b00;
    localparam logic [1:0] STC_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [1:0] prescale_select;
        logic oscillator_enable;
        logic sync_bypass;
        logic clock_source_select;
        logic count_on;
    } stc_ctrl_s;

    typedef struct packed {
        logic [1:0] pin_oe_n;
        logic [1:0] pin_read;
    } stc_pins_s;

    function automatic logic [STC_ADDR_W-1:0] stc_byte_addr(
        input logic [7:0] idx);
        stc_byte_addr = {idx, 2'b00};
    endfunction : stc_byte_addr
endpackage : stc_pkg

// file: rtl/stc_edge_sync.sv
// two-flop synchroniser with rising-edge pulse on the second stage
`timescale 1ns/10ps
`default_nettype none
module stc_edge_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // raw input and bypass select
    input wire logic raw_in,
    input wire logic bypass,
    // rising edge, one cycle
    output logic rise_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic r1;
    } stc_sync_s;

    stc_sync_s st_q;
    stc_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = raw_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.r1 = raw_in;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // unsynchronised path flags the edge in the same cycle the pin moves
    assign rise_pulse = bypass ? (raw_in & ~st_q.r1) : (st_q.s2 & ~st_q.s3);
endmodule : stc_edge_sync
`default_nettype wire

// file: rtl/stc_timer.sv
// sixteen-bit timer counter with axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module stc_timer
    import stc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [STC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [STC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // count sources
    input wire logic instr_tick,
    input wire logic ext_clk_in,
    input wire logic special_event_clr,
    // oscillator pins and port direction
    input wire logic [1:0] osc_pin_in,
    input wire logic [1:0] port_direction,
    output logic [1:0] osc_pin_oe_n,
    output logic [1:0] osc_pin_read,
    output logic osc_inverter_en,
    // interrupt
    output logic overflow_irq
);
    typedef struct packed {
        logic [STC_ADDR_W-1:0] awaddr;
        logic aw_held;
        logic [7:0] wbyte;
        logic w_held;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        stc_ctrl_s ctrl;
        logic [15:0] count;
        logic [2:0] presc;
        logic overflow_flag;
        logic overflow_irq_enable;
        stc_pins_s pins;
    } stc_state_s;

    stc_state_s st_q;
    stc_state_s st_d;
    logic ext_rise;
    logic src_tick;
    logic presc_out;
    logic do_write;
    logic do_read;
    logic [STC_ADDR_W-1:0] wr_addr;

    function automatic logic is_mapped(input logic [STC_ADDR_W-1:0] a);
        is_mapped = (a == stc_byte_addr(STC_IDX_FLAGS))
            || (a == stc_byte_addr(STC_IDX_CNT_LO))
            || (a == stc_byte_addr(STC_IDX_CNT_HI))
            || (a == stc_byte_addr(STC_IDX_CTRL))
            || (a == stc_byte_addr(STC_IDX_ENABLES))
            || (a == stc_byte_addr(STC_IDX_FLAG_CLR));
    endfunction : is_mapped

    stc_edge_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .raw_in(ext_clk_in),
        .bypass(st_q.ctrl.sync_bypass),
        .rise_pulse(ext_rise)
    );

    assign src_tick = st_q.ctrl.clock_source_select ? ext_rise : instr_tick;

    always_comb begin
        unique case (st_q.ctrl.prescale_select)
            2'b00: presc_out = src_tick;
            2'b01: presc_out = src_tick & st_q.presc[0];
            2'b10: presc_out = src_tick & (&st_q.presc[1:0]);
            2'b11: presc_out = src_tick & (&st_q.presc);
        endcase
    end

    assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
    assign s_axi_wready = !st_q.w_held && !st_q.bvalid;
    assign s_axi_arready = !st_q.rvalid;
    assign wr_addr = st_q.aw_held ? st_q.awaddr : s_axi_awaddr;
    assign do_write = (st_q.aw_held || (s_axi_awvalid && s_axi_awready))
        && (st_q.w_held || (s_axi_wvalid && s_axi_wready)) && !st_q.bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_comb begin
        logic [7:0] wb;
        logic [15:0] cnt;
        logic wrap;
        wb = st_q.w_held ? st_q.wbyte : s_axi_wdata[7:0];
        cnt = st_q.count;
        wrap = 1'b0;
        st_d = st_q;
        // write channel capture, either order
        if (s_axi_awvalid && s_axi_awready && !do_write) begin
            st_d.aw_held = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !do_write) begin
            st_d.w_held = 1'b1;
            st_d.wbyte = s_axi_wdata[7:0];
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        // gate on count_on; count held when stopped
        if (st_q.ctrl.count_on && src_tick) begin
            st_d.presc = presc_out ? 3'h0 : st_q.presc + 3'h1;
        end
        if (st_q.ctrl.count_on && presc_out) begin
            cnt = st_q.count + 16'h0001;
            wrap = (st_q.count == STC_COUNT_ALL_ONES);
        end
        if (special_event_clr) begin
            cnt = STC_COUNT_ZERO;
            st_d.presc = 3'h0;
        end
        if (do_write) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = is_mapped(wr_addr) ? STC_RESP_OKAY : STC_RESP_SLVERR;
            if (s_axi_wstrb[0] || st_q.w_held) begin
                if (wr_addr == stc_byte_addr(STC_IDX_CNT_LO)) begin
                    cnt[7:0] = wb;
                end
                if (wr_addr == stc_byte_addr(STC_IDX_CNT_HI)) begin
                    cnt[15:8] = wb;
                end
                if (wr_addr == stc_byte_addr(STC_IDX_CTRL)) begin
                    st_d.ctrl = stc_ctrl_s'(wb[5:0] & STC_CTRL_MASK);
                end
                if (wr_addr == stc_byte_addr(STC_IDX_ENABLES)) begin
                    st_d.overflow_irq_enable = wb[STC_FLAG_OVF];
                end
                if (wr_addr == stc_byte_addr(STC_IDX_FLAG_CLR)
                        && wb[STC_FLAG_OVF]) begin
                    st_d.overflow_flag = 1'b0;
                end
            end
        end
        st_d.count = cnt;
        // sticky flag, set wins over clear
        if (wrap) begin
            st_d.overflow_flag = 1'b1;
        end
        if (do_read) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = is_mapped(s_axi_araddr) ? STC_RESP_OKAY
                : STC_RESP_SLVERR;
            st_d.rdata = 32'h0000_0000;
            if (s_axi_araddr == stc_byte_addr(STC_IDX_FLAGS)) begin
                st_d.rdata[STC_FLAG_OVF] = st_q.overflow_flag;
            end
            if (s_axi_araddr == stc_byte_addr(STC_IDX_CNT_LO)) begin
                st_d.rdata[7:0] = st_q.count[7:0];
            end
            if (s_axi_araddr == stc_byte_addr(STC_IDX_CNT_HI)) begin
                st_d.rdata[7:0] = st_q.count[15:8];
            end
            if (s_axi_araddr == stc_byte_addr(STC_IDX_CTRL)) begin
                st_d.rdata[5:0] = st_q.ctrl;
            end
            if (s_axi_araddr == stc_byte_addr(STC_IDX_ENABLES)) begin
                st_d.rdata[STC_FLAG_OVF] = st_q.overflow_irq_enable;
            end
        end
        // oscillator enabled: pins forced to inputs, read as zero; else follow port_direction and osc_pin_in
        if (st_q.ctrl.oscillator_enable) begin
            st_d.pins.pin_oe_n = 2'b11;
            st_d.pins.pin_read = 2'b00;
        end else begin
            st_d.pins.pin_oe_n = port_direction;
            st_d.pins.pin_read = osc_pin_in;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.pins.pin_oe_n <= 2'b11;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign osc_pin_oe_n = st_q.pins.pin_oe_n;
    assign osc_pin_read = st_q.pins.pin_read;
    assign osc_inverter_en = st_q.ctrl.oscillator_enable;
    assign overflow_irq = st_q.overflow_flag & st_q.overflow_irq_enable;

    a_wrap_to_zero: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.count == STC_COUNT_ALL_ONES && st_q.ctrl.count_on && presc_out
        && !special_event_clr && !do_write) |=> st_q.count == STC_COUNT_ZERO)
        else $error("count did not wrap to zero");
    a_flag_on_wrap: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.count == STC_COUNT_ALL_ONES && st_q.ctrl.count_on && presc_out
        && !special_event_clr) |=> st_q.overflow_flag)
        else $error("overflow flag not set on wrap");
    a_flag_sticky: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.overflow_flag
        && !(do_write && wr_addr == stc_byte_addr(STC_IDX_FLAG_CLR)))
        |=> st_q.overflow_flag)
        else $error("overflow flag cleared without a clear write");
    a_irq_masked: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !st_q.overflow_irq_enable |-> !overflow_irq)
        else $error("interrupt raised while masked");
    a_ext_only: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.ctrl.clock_source_select && !ext_rise && !special_event_clr
        && !do_write) |=> $stable(st_q.count))
        else $error("count moved without an external edge");
    a_internal_tick: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.ctrl.count_on && !st_q.ctrl.clock_source_select
        && st_q.ctrl.prescale_select == 2'b00 && instr_tick
        && !special_event_clr && !do_write)
        |=> st_q.count == $past(st_q.count) + 16'h0001)
        else $error("internal tick did not advance count");
    a_external_edge: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.ctrl.count_on && st_q.ctrl.clock_source_select
        && st_q.ctrl.prescale_select == 2'b00 && ext_rise
        && !special_event_clr && !do_write)
        |=> st_q.count == $past(st_q.count) + 16'h0001)
        else $error("external edge did not advance count");
    a_stop_holds: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (!st_q.ctrl.count_on && !special_event_clr && !do_write)
        |=> $stable(st_q.count))
        else $error("count moved while stopped");
    a_event_clear: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (special_event_clr && !do_write) |=> st_q.count == STC_COUNT_ZERO)
        else $error("special event did not clear count");
    a_osc_pins: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        st_q.ctrl.oscillator_enable |=> (osc_pin_oe_n == 2'b11
        && osc_pin_read == 2'b00))
        else $error("oscillator pins not forced to inputs");
    a_osc_pins_off: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !st_q.ctrl.oscillator_enable
        |=> osc_pin_oe_n == $past(port_direction))
        else $error("pin direction not followed");
    a_presc_count: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (st_q.ctrl.count_on && src_tick && !presc_out && !special_event_clr)
        |=> st_q.presc == $past(st_q.presc) + 3'h1)
        else $error("prescaler missed a tick");
    a_presc_eight: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (presc_out && st_q.ctrl.prescale_select == 2'b11)
        |-> st_q.presc == 3'h7)
        else $error("prescale 1:8 fired early");
    a_sync_delay: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        ($rose(ext_clk_in) && !st_q.ctrl.sync_bypass)
        |-> ##2 (ext_rise || st_q.ctrl.sync_bypass))
        else $error("synchronised edge not seen in time");
    a_raw_edge: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        ($rose(ext_clk_in) && st_q.ctrl.sync_bypass) |-> ext_rise)
        else $error("unsynchronised edge not seen");
    a_count_read: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (do_read && s_axi_araddr == stc_byte_addr(STC_IDX_CNT_LO))
        |=> s_axi_rdata[7:0] == $past(st_q.count[7:0]))
        else $error("low count byte read wrong");
    a_byte_load: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (do_write && !st_q.w_held && s_axi_wstrb[0]
        && wr_addr == stc_byte_addr(STC_IDX_CNT_HI))
        |=> st_q.count[15:8] == $past(s_axi_wdata[7:0]))
        else $error("high count byte not loaded");
endmodule : stc_timer
`default_nettype wire

// file: verif/stc_clk_src.sv
// behavioural external count clock source for the timer counter
`timescale 1ns/10ps
`default_nettype none
module stc_clk_src (
    // count clock pin
    output logic ext_clk
);
    // the pin stands low between bursts
    initial ext_clk = 1'b0;

    // burst of rising edges 3 ns past a core clock edge; half periods in
    // whole clock periods keep every later transition off the edges too
    task automatic pulses(input int n, input int half_ns);
        #3;
        repeat (n) begin
            ext_clk = 1'b1;
            #(half_ns);
            ext_clk = 1'b0;
            #(half_ns);
        end
    endtask : pulses
endmodule : stc_clk_src
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the sixteen-bit timer counter
`timescale 1ns/10ps
`default_nettype none
module tb;
    import stc_pkg::*;
    logic core_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, instr_tick = 0, clr = 0;
    logic [9:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] pin_in = 2'b11, dir = 2'b01;
    wire logic awready, wready, bvalid, arready, rvalid, ext_clk, inv_en, irq;
    wire logic [1:0] bresp, rresp, oe_n, pin_rd;
    wire logic [31:0] rdata;
    logic [33:0] exp_q[$];
    logic [15:0] v;
    int errors = 0, samples_checked = 0;
    logic [1:0] wresp = STC_RESP_OKAY;

    stc_timer uut (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .instr_tick(instr_tick), .ext_clk_in(ext_clk),
        .special_event_clr(clr), .osc_pin_in(pin_in), .port_direction(dir),
        .osc_pin_oe_n(oe_n), .osc_pin_read(pin_rd), .osc_inverter_en(inv_en),
        .overflow_irq(irq));
    stc_clk_src src (.ext_clk(ext_clk));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim();
        if (exp_q.size() != 0) errors++;
        $display("checked %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic hang();
        errors++;
        $display("mismatch at %0t: bus wait timed out", $time);
        end_sim();
    endtask : hang

    // read and write responses are compared in arrival order
    always @(posedge core_clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (exp_q.size() == 0) check({rresp, rdata}, 34'h3FFFFFFFF);
            else check({rresp, rdata}, exp_q.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (exp_q.size() == 0) check({bresp, 32'h0}, 34'h3FFFFFFFF);
            else check({bresp, 32'h0}, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        int n;
        exp_q.push_back({wresp, 32'h0});
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            aw_t = awvalid & awready;
            w_t = wvalid & wready;
            b_t = bvalid;
            @(posedge core_clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) break;
        end
        bready <= 1'b0;
        if (n == 50) hang();
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
        logic ar_t, r_t;
        int n;
        exp_q.push_back(exp);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ar_t = arvalid & arready;
            r_t = rvalid;
            @(posedge core_clk);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) break;
        end
        rready <= 1'b0;
        if (n == 50) hang();
        @(posedge core_clk);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) begin
            instr_tick <= 1'b1;
            @(posedge core_clk);
            instr_tick <= 1'b0;
            @(posedge core_clk);
        end
    endtask : tick

    task automatic pulse_clr();
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        @(posedge core_clk);
    endtask : pulse_clr

    initial begin
        void'($urandom(71));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(STC_IDX_CTRL, 34'h0);
        rd(STC_IDX_FLAGS, 34'h0);
        rd(STC_IDX_ENABLES, 34'h0);
        rd(8'hFF, {STC_RESP_SLVERR, 32'h0});
        wresp = STC_RESP_SLVERR;
        wr(8'hFF, 8'h01);
        wresp = STC_RESP_OKAY;
        wstrb <= 4'h0;
        wr(STC_IDX_CTRL, 8'h01);
        wstrb <= 4'hF;
        rd(STC_IDX_CTRL, 34'h0);
        wr(STC_IDX_CTRL, 8'hC0);
        rd(STC_IDX_CTRL, 34'h0);
        $display("test reset values done");
        for (int p = 0; p < 4; p++) begin
            pulse_clr();
            wr(STC_IDX_CTRL, {2'b00, p[1:0], 4'h1});
            tick(8);
            wr(STC_IDX_CTRL, 8'h00);
            tick(2);
            rd(STC_IDX_CNT_LO, 34'(8 >> p));
        end
        $display("test prescale done");
        v = 16'($urandom);
        wr(STC_IDX_CNT_LO, v[7:0]);
        wr(STC_IDX_CNT_HI, v[15:8]);
        rd(STC_IDX_CNT_LO, {26'h0, v[7:0]});
        rd(STC_IDX_CNT_HI, {26'h0, v[15:8]});
        wr(STC_IDX_ENABLES, 8'h01);
        wr(STC_IDX_CNT_LO, 8'hFF);
        wr(STC_IDX_CNT_HI, 8'hFF);
        wr(STC_IDX_CTRL, 8'h01);
        check({33'h0, irq}, 34'h0);
        tick(1);
        wr(STC_IDX_CTRL, 8'h00);
        rd(STC_IDX_CNT_LO, 34'h0);
        rd(STC_IDX_CNT_HI, 34'h0);
        rd(STC_IDX_FLAGS, 34'h1);
        check({33'h0, irq}, 34'h1);
        wr(STC_IDX_ENABLES, 8'h00);
        check({33'h0, irq}, 34'h0);
        rd(STC_IDX_FLAGS, 34'h1);
        wr(STC_IDX_ENABLES, 8'h01);
        wr(STC_IDX_FLAG_CLR, 8'h01);
        rd(STC_IDX_FLAGS, 34'h0);
        check({33'h0, irq}, 34'h0);
        $display("test overflow done");
        for (int s = 0; s < 2; s++) begin
            pulse_clr();
            v = 16'($urandom);
            wr(STC_IDX_CNT_LO, v[7:0]);
            wr(STC_IDX_CNT_HI, v[15:8]);
            wr(STC_IDX_CTRL, {5'h00, s[0], 2'b11});
            src.pulses(4, 10 + 15 * s);
            repeat (6) @(posedge core_clk);
            wr(STC_IDX_CTRL, 8'h00);
            v = v + 16'h0004;
            rd(STC_IDX_CNT_LO, {26'h0, v[7:0]});
            rd(STC_IDX_CNT_HI, {26'h0, v[15:8]});
        end
        wr(STC_IDX_CTRL, 8'h01);
        tick(3);
        wr(STC_IDX_CTRL, 8'h00);
        v = v + 16'h0003;
        rd(STC_IDX_CNT_LO, {26'h0, v[7:0]});
        $display("test external clock done");
        pin_in <= 2'b10;
        repeat (2) @(posedge core_clk);
        check({30'h0, oe_n, pin_rd}, 34'h6);
        check({33'h0, inv_en}, 34'h0);
        wr(STC_IDX_CTRL, 8'h08);
        @(posedge core_clk);
        check({30'h0, oe_n, pin_rd}, 34'hC);
        check({33'h0, inv_en}, 34'h1);
        $display("test oscillator pins done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
